// ==== hw/dps_host.sv ====
// Operation
// - to request a token, write zero to the latch, then read it back.
// - after a latch write keep latch select high for the recovery gap.
// - reading zero means token owned; reading one means keep polling.
// - latch select low acts as chip select; array select stays high.
`timescale 1ns/10ps
module dps_host (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [1:0] i_req_op,
  input wire logic [dps_pkg::ADDR_W-1:0] i_req_addr,
  input wire logic [dps_pkg::DATA_W-1:0] i_req_data,
  input wire logic [1:0] i_req_byte_en,
  input wire logic i_cancel,
  output logic o_rsp_valid,
  output logic [dps_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_rsp_granted,
  output logic o_rsp_busy,
  output logic o_polling,
  output logic o_mailbox_pending,
  output logic [dps_pkg::ADDR_W-1:0] o_addr,
  output logic o_array_select_n,
  output logic o_latch_select_n,
  output logic o_rw_n,
  output logic o_oe_n,
  output logic o_upper_byte_select_n,
  output logic o_lower_byte_select_n,
  output logic [dps_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic [dps_pkg::DATA_W-1:0] i_dq,
  input wire logic i_busy_n,
  input wire logic i_mailbox_int_n
);
  typedef struct packed {
    dps_pkg::dps_main_e st;
    dps_pkg::dps_op_e op;
    logic wr;
    logic latch;
    logic start;
    logic cancel_pend;
    logic rsp_valid;
    logic granted;
    logic busy_hit;
    logic [dps_pkg::CNT_W-1:0] cnt;
    logic [dps_pkg::ADDR_W-1:0] addr;
    logic [1:0] be_n;
    logic [dps_pkg::DATA_W-1:0] data;
    logic [dps_pkg::DATA_W-1:0] rsp_data;
    logic [dps_pkg::SYNC_W-1:0] s1;
    logic [dps_pkg::SYNC_W-1:0] s2;
    logic [dps_pkg::SYNC_W-1:0] s3;
    logic [dps_pkg::SYNC_W-1:0] sf;
  } dps_host_s;

  dps_host_s r;
  dps_host_s next_r;
  dps_cyc_if cyc ();
  dps_pkg::dps_op_e req_op;
  logic tok;
  logic seen_done;

  assign req_op = dps_pkg::dps_op_e'(i_req_op);
  assign tok = cyc.rdata[0];
  assign seen_done = cyc.done;

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.rsp_valid = 1'b0;
    // pins: three stages, a bit moves once stages two and three agree
    next_r.s1 = {i_mailbox_int_n, i_busy_n, i_dq};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.sf = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.sf);
    if (i_cancel && r.st != dps_pkg::M_IDLE) begin
      next_r.cancel_pend = 1'b1;
    end
    case (r.st)
      dps_pkg::M_IDLE: begin
        if (i_req_valid) begin
          next_r.op = req_op;
          next_r.cancel_pend = 1'b0;
          next_r.latch = req_op[1];
          next_r.wr = (req_op != dps_pkg::OP_MEM_RD);
          next_r.be_n = ~i_req_byte_en;
          next_r.start = 1'b1;
          next_r.st = dps_pkg::M_ACCESS;
          if (req_op[1]) begin
            next_r.addr = {11'h000, i_req_addr[dps_pkg::LATCH_IDX_W-1:0]};
            // token in bit zero, copied on all lines
            next_r.data = {dps_pkg::DATA_W{req_op == dps_pkg::OP_SEM_GIVE}};
          end else begin
            next_r.addr = i_req_addr;
            next_r.data = i_req_data;
          end
        end
      end
      dps_pkg::M_ACCESS: begin
        if (seen_done) begin
          if (r.op == dps_pkg::OP_SEM_TAKE) begin
            next_r.cnt = dps_pkg::GAP_CYC - dps_pkg::CNT_ONE;
            next_r.st = dps_pkg::M_GAP;
          end else if (r.op == dps_pkg::OP_MEM_WR && cyc.busy_hit) begin
            // a write under busy may miss the mailbox; repeat it
            next_r.start = 1'b1;
          end else begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = cyc.rdata;
            next_r.granted = 1'b0;
            next_r.busy_hit = cyc.busy_hit;
            next_r.st = dps_pkg::M_IDLE;
          end
        end
      end
      dps_pkg::M_GAP: begin
        if (r.cnt == '0) begin
          next_r.wr = 1'b0;
          next_r.start = 1'b1;
          next_r.st = dps_pkg::M_READ;
        end else begin
          next_r.cnt = r.cnt - dps_pkg::CNT_ONE;
        end
      end
      dps_pkg::M_READ: begin
        if (seen_done) begin
          if (tok == dps_pkg::TOKEN_REQUEST) begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = cyc.rdata;
            next_r.granted = 1'b1;
            next_r.busy_hit = 1'b0;
            next_r.st = dps_pkg::M_IDLE;
          end else if (r.cancel_pend) begin
            // withdraw the request by writing one
            next_r.op = dps_pkg::OP_SEM_GIVE;
            next_r.wr = 1'b1;
            next_r.data = {dps_pkg::DATA_W{dps_pkg::TOKEN_RELEASE}};
            next_r.start = 1'b1;
            next_r.st = dps_pkg::M_ACCESS;
          end else begin
            // far port holds it; our request stays pending
            next_r.cnt = dps_pkg::POLL_CYC - dps_pkg::CNT_ONE;
            next_r.st = dps_pkg::M_GAP;
          end
        end
      end
      default: begin
        next_r.st = dps_pkg::M_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '{st: dps_pkg::M_IDLE, op: dps_pkg::OP_MEM_RD, s1: dps_pkg::SYNC_RST,
             s2: dps_pkg::SYNC_RST, s3: dps_pkg::SYNC_RST, sf: dps_pkg::SYNC_RST,
             be_n: 2'h3, default: '0};
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  assign cyc.start = r.start;
  assign cyc.is_write = r.wr;
  assign cyc.is_latch = r.latch;
  assign cyc.addr = r.addr;
  assign cyc.wdata = r.data;
  assign cyc.be_n = r.be_n;
  assign cyc.pin_dq = r.sf[dps_pkg::DATA_W-1:0];
  assign cyc.pin_busy_n = r.sf[dps_pkg::DATA_W];

  assign o_req_ready = (r.st == dps_pkg::M_IDLE);
  assign o_rsp_valid = r.rsp_valid;
  assign o_rsp_data = r.rsp_data;
  assign o_rsp_granted = r.granted;
  assign o_rsp_busy = r.busy_hit;
  assign o_polling = r.latch && (r.st == dps_pkg::M_GAP || r.st == dps_pkg::M_READ);
  // the device clears this itself when our mailbox is read while busy is not asserted
  assign o_mailbox_pending = ~r.sf[dps_pkg::SYNC_W-1];

  dps_pin_seq u_seq (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .cyc(cyc.seq),
    .o_addr(o_addr),
    .o_array_select_n(o_array_select_n),
    .o_latch_select_n(o_latch_select_n),
    .o_rw_n(o_rw_n),
    .o_oe_n(o_oe_n),
    .o_upper_byte_select_n(o_upper_byte_select_n),
    .o_lower_byte_select_n(o_lower_byte_select_n),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe)
  );

  a_no_dual_select: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !(!o_array_select_n && !o_latch_select_n))
    else $error("array and latch selected together");
  a_latch_bytes_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_latch_select_n |-> (o_upper_byte_select_n && o_lower_byte_select_n && o_array_select_n))
    else $error("byte or array select low in latch access");
  a_take_writes_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !i_clk_en)
    (r.start && r.wr && r.op == dps_pkg::OP_SEM_TAKE) |-> (r.data[0] == 1'b0 && r.latch))
    else $error("take does not write zero");
  a_gap_after_write: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !i_clk_en)
    (r.st == dps_pkg::M_ACCESS && seen_done && r.op == dps_pkg::OP_SEM_TAKE)
    |=> (o_latch_select_n && r.st == dps_pkg::M_GAP) [*2] ##1 o_latch_select_n)
    else $error("latch read back without recovery gap");
  a_grant_on_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !i_clk_en)
    (r.st == dps_pkg::M_READ && seen_done && !tok) |=> (o_rsp_valid && o_rsp_granted))
    else $error("zero read not reported as granted");
  a_poll_on_one: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !i_clk_en)
    (r.st == dps_pkg::M_READ && seen_done && tok && !r.cancel_pend)
    |=> (!o_rsp_valid && r.st == dps_pkg::M_GAP && r.cnt == dps_pkg::POLL_CYC - 8'h01))
    else $error("one read did not lead to polling");
  a_cancel_release: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !i_clk_en)
    (r.st == dps_pkg::M_READ && seen_done && tok && r.cancel_pend)
    |=> (r.start && r.wr && r.data[0] && r.st == dps_pkg::M_ACCESS))
    else $error("cancel did not write one");
  a_busy_write_retry: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !i_clk_en)
    (r.st == dps_pkg::M_ACCESS && seen_done && r.op == dps_pkg::OP_MEM_WR && cyc.busy_hit)
    |=> (r.start && !o_rsp_valid && r.st == dps_pkg::M_ACCESS))
    else $error("write under busy not repeated");
  a_latch_addr_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_latch_select_n |-> (o_addr[dps_pkg::ADDR_W-1:dps_pkg::LATCH_IDX_W] == '0))
    else $error("upper address bits set in latch access");

  c_grant: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_rsp_valid && o_rsp_granted);
  c_poll: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    r.st == dps_pkg::M_READ && seen_done && tok);
  c_cancel: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    r.op == dps_pkg::OP_SEM_GIVE && r.cancel_pend && o_rsp_valid);
  c_mem_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_array_select_n && !o_rw_n);
  c_busy_retry: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    r.op == dps_pkg::OP_MEM_WR && cyc.busy_hit && seen_done);
endmodule : dps_host

// ==== hw/dps_pin_seq.sv ====
`timescale 1ns/10ps
module dps_pin_seq (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  dps_cyc_if.seq cyc,
  output logic [dps_pkg::ADDR_W-1:0] o_addr,
  output logic o_array_select_n,
  output logic o_latch_select_n,
  output logic o_rw_n,
  output logic o_oe_n,
  output logic o_upper_byte_select_n,
  output logic o_lower_byte_select_n,
  output logic [dps_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe
);
  typedef struct packed {
    dps_pkg::dps_seq_e st;
    logic [dps_pkg::CNT_W-1:0] cnt;
    logic [dps_pkg::ADDR_W-1:0] addr;
    logic ce_n;
    logic sem_n;
    logic rw_n;
    logic oe_n;
    logic [1:0] bs_n;
    logic [dps_pkg::DATA_W-1:0] dq;
    logic dq_oe;
    logic [dps_pkg::DATA_W-1:0] rdata;
    logic busy_hit;
    logic done;
  } dps_seq_s;

  dps_seq_s r;
  dps_seq_s next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      dps_pkg::S_IDLE: begin
        if (cyc.start) begin
          next_r.addr = cyc.addr;
          next_r.dq = cyc.wdata;
          next_r.dq_oe = cyc.is_write;
          // byte selects stay off on latch cycles
          next_r.bs_n = cyc.is_latch ? 2'h3 : cyc.be_n;
          next_r.cnt = dps_pkg::SETUP_CYC - dps_pkg::CNT_ONE;
          next_r.st = dps_pkg::S_SETUP;
        end
      end
      dps_pkg::S_SETUP: begin
        if (r.cnt == '0) begin
          // never both selects low together
          next_r.ce_n = cyc.is_latch;
          next_r.sem_n = ~cyc.is_latch;
          next_r.rw_n = ~cyc.is_write;
          next_r.oe_n = cyc.is_write;
          next_r.cnt = (cyc.is_write ? dps_pkg::STROBE_WR_CYC : dps_pkg::STROBE_RD_CYC)
                       - dps_pkg::CNT_ONE;
          next_r.st = dps_pkg::S_STROBE;
        end else begin
          next_r.cnt = r.cnt - dps_pkg::CNT_ONE;
        end
      end
      dps_pkg::S_STROBE: begin
        if (r.cnt == '0) begin
          next_r.rdata = cyc.pin_dq;
          next_r.busy_hit = ~cyc.pin_busy_n;
          next_r.ce_n = 1'b1;
          next_r.sem_n = 1'b1;
          next_r.rw_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.cnt = dps_pkg::HOLD_CYC - dps_pkg::CNT_ONE;
          next_r.st = dps_pkg::S_HOLD;
        end else begin
          next_r.cnt = r.cnt - dps_pkg::CNT_ONE;
        end
      end
      dps_pkg::S_HOLD: begin
        if (r.cnt == '0) begin
          // data held past the rising write edge, then released
          next_r.dq_oe = 1'b0;
          next_r.bs_n = 2'h3;
          next_r.done = 1'b1;
          next_r.st = dps_pkg::S_IDLE;
        end else begin
          next_r.cnt = r.cnt - dps_pkg::CNT_ONE;
        end
      end
      default: begin
        next_r.st = dps_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '{st: dps_pkg::S_IDLE, ce_n: 1'b1, sem_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
             bs_n: 2'h3, default: '0};
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  assign o_addr = r.addr;
  assign o_array_select_n = r.ce_n;
  assign o_latch_select_n = r.sem_n;
  assign o_rw_n = r.rw_n;
  assign o_oe_n = r.oe_n;
  assign o_upper_byte_select_n = r.bs_n[1];
  assign o_lower_byte_select_n = r.bs_n[0];
  assign o_dq = r.dq;
  assign o_dq_oe = r.dq_oe;
  assign cyc.done = r.done;
  assign cyc.rdata = r.rdata;
  assign cyc.busy_hit = r.busy_hit;

  a_idle_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (r.st == dps_pkg::S_IDLE) |-> (r.ce_n && r.sem_n && r.oe_n && r.rw_n))
    else $error("port not quiet while idle");
endmodule : dps_pin_seq

// ==== pkg/dps_cyc_if.sv ====
`timescale 1ns/10ps
interface dps_cyc_if;
  logic start;
  logic is_write;
  logic is_latch;
  logic [dps_pkg::ADDR_W-1:0] addr;
  logic [dps_pkg::DATA_W-1:0] wdata;
  logic [1:0] be_n;
  logic [dps_pkg::DATA_W-1:0] pin_dq;
  logic pin_busy_n;
  logic done;
  logic [dps_pkg::DATA_W-1:0] rdata;
  logic busy_hit;
  modport ctl (output start, is_write, is_latch, addr, wdata, be_n, pin_dq, pin_busy_n,
               input done, rdata, busy_hit);
  modport seq (input start, is_write, is_latch, addr, wdata, be_n, pin_dq, pin_busy_n,
               output done, rdata, busy_hit);
endinterface : dps_cyc_if

// ==== pkg/dps_pkg.sv ====
package dps_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 18;
  localparam int LATCH_IDX_W = 3;
  localparam int SYNC_W = DATA_W + 2;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_NS = 10;

  // least times, rounded up, never below one cycle
  function automatic int dps_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dps_cyc_up

  // pin timing figures, plain defaults for the slowest grade assumed
  localparam int ADDR_SETUP_NS = 10;
  localparam int ACCESS_TIME_NS = 20;
  localparam int WRITE_PULSE_NS = 20;
  localparam int HOLD_NS = 10;
  localparam int LATCH_RECOVERY_GAP_NS = 10;
  localparam int LATCH_WRITE_TO_READ_DELAY_NS = 10;
  localparam int POLL_GAP_NS = 100;
  localparam int SYNC_LAT_CYC = 4;

  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(dps_cyc_up(ADDR_SETUP_NS));
  localparam logic [CNT_W-1:0] STROBE_RD_CYC =
    CNT_W'(dps_cyc_up(ACCESS_TIME_NS) + SYNC_LAT_CYC);
  localparam logic [CNT_W-1:0] STROBE_WR_CYC =
    CNT_W'(dps_cyc_up(WRITE_PULSE_NS) + SYNC_LAT_CYC);
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(dps_cyc_up(HOLD_NS));
  localparam logic [CNT_W-1:0] GAP_CYC =
    CNT_W'(dps_cyc_up(LATCH_RECOVERY_GAP_NS) + dps_cyc_up(LATCH_WRITE_TO_READ_DELAY_NS));
  localparam logic [CNT_W-1:0] POLL_CYC = CNT_W'(dps_cyc_up(POLL_GAP_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  localparam logic [ADDR_W-1:0] MAILBOX_RIGHT_ADDR = 14'h3FFF;
  localparam logic [ADDR_W-1:0] MAILBOX_LEFT_ADDR = 14'h3FFE;
  localparam logic TOKEN_REQUEST = 1'h0;
  localparam logic TOKEN_RELEASE = 1'h1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'hFFFFF;

  typedef enum logic [1:0] {
    OP_MEM_RD = 2'h0,
    OP_MEM_WR = 2'h1,
    OP_SEM_TAKE = 2'h2,
    OP_SEM_GIVE = 2'h3
  } dps_op_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_ACCESS = 2'h1,
    M_GAP = 2'h3,
    M_READ = 2'h2
  } dps_main_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_SETUP = 2'h1,
    S_STROBE = 2'h3,
    S_HOLD = 2'h2
  } dps_seq_e;
endpackage : dps_pkg

// ==== tb/dps_dev_model.sv ====
`timescale 1ns/10ps
module dps_dev_model (
  input wire logic [13:0] i_addr,
  input wire logic i_array_select_n,
  input wire logic i_latch_select_n,
  input wire logic i_rw_n,
  input wire logic i_oe_n,
  input wire logic i_upper_byte_select_n,
  input wire logic i_lower_byte_select_n,
  input wire logic [17:0] i_dq,
  input wire logic i_far_sem_wr,
  input wire logic i_far_mem_wr,
  input wire logic [13:0] i_far_addr,
  input wire logic i_far_bit,
  input wire logic i_force_busy,
  output logic [17:0] o_dq,
  output logic o_busy_n,
  output logic o_int_n,
  output logic o_far_int_n,
  output logic [7:0] o_sem_l,
  output logic [7:0] o_sem_r,
  output logic o_viol
);
  logic [17:0] mem [0:16383];
  logic [7:0] held [2] = '{8'h00, 8'h00}; // eight latches, free at power-up
  logic [7:0] req [2] = '{8'h00, 8'h00};
  logic [13:0] w_addr, r_addr;
  logic [17:0] w_dq, last;
  logic w_sem, w_ub_n, w_lb_n, r_arr, rd_tok, w_act, r_act;
  realtime t_wend = -1000.0;
  assign w_act = !i_rw_n && (!i_array_select_n || !i_latch_select_n);
  assign r_act = i_rw_n && !i_oe_n && (!i_array_select_n || !i_latch_select_n);
  // no arbitration modelled; busy only when the bench asks for it
  assign o_busy_n = !i_force_busy;
  assign o_sem_l = ~held[0];
  assign o_sem_r = ~held[1];
  initial begin
    o_int_n = 1'b1;
    o_far_int_n = 1'b1;
    o_viol = 1'b0;
  end
  // events are serialised, so a tie still yields one owner
  task automatic sem_wr(input logic s, input logic [2:0] i, input logic v);
    req[s][i] = ~v;
    if (!v && !held[~s][i]) held[s][i] = 1'b1;
    if (v && held[s][i]) begin
      held[s][i] = 1'b0;
      held[~s][i] = req[~s][i];
    end
  endtask : sem_wr
  // capture at strobe start: selects and rw rise together at the end
  always @(posedge w_act) begin
    w_addr = i_addr;
    w_dq = i_dq;
    w_sem = !i_latch_select_n;
    w_ub_n = i_upper_byte_select_n;
    w_lb_n = i_lower_byte_select_n;
  end
  always @(negedge w_act) begin
    if (w_sem) begin
      sem_wr(1'b0, w_addr[2:0], w_dq[0]);
      t_wend = $realtime;
    end else begin
      if (!w_ub_n) mem[w_addr][17:9] = w_dq[17:9];
      if (!w_lb_n) mem[w_addr][8:0] = w_dq[8:0];
      if (w_addr == dps_pkg::MAILBOX_RIGHT_ADDR && o_busy_n) o_far_int_n = 1'b0;
    end
  end
  always @(posedge r_act) begin
    r_addr = i_addr;
    r_arr = !i_array_select_n;
    rd_tok = ~held[0][i_addr[2:0]]; // held in output register
    last = !i_latch_select_n ? {18{rd_tok}} : mem[i_addr];
    if (!i_latch_select_n && $realtime - t_wend < dps_pkg::LATCH_RECOVERY_GAP_NS) begin
      o_viol = 1'b1;
    end
  end
  always @(negedge r_act) begin
    // a busy port cannot clear its own flag
    if (r_arr && r_addr == dps_pkg::MAILBOX_LEFT_ADDR && o_busy_n) o_int_n = 1'b1;
  end
  always @(negedge i_array_select_n or negedge i_latch_select_n) begin
    #1 if (!i_array_select_n && !i_latch_select_n) o_viol = 1'b1;
  end
  always @(posedge i_far_sem_wr) sem_wr(1'b1, i_far_addr[2:0], i_far_bit);
  always @(posedge i_far_mem_wr) begin
    if (i_far_addr == dps_pkg::MAILBOX_LEFT_ADDR) o_int_n = 1'b0;
  end
  // released lines show the inverse of the last word, not a kind constant
  always @* begin
    o_dq = ~last;
    if (r_act && !i_latch_select_n) o_dq = {18{rd_tok}};
    else if (r_act) begin
      if (!i_upper_byte_select_n) o_dq[17:9] = mem[i_addr][17:9];
      if (!i_lower_byte_select_n) o_dq[8:0] = mem[i_addr][8:0];
    end
  end
endmodule : dps_dev_model

// ==== tb/dps_host_bench.sv ====
`timescale 1ns/10ps
module dps_host_bench;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_req_valid = 1'b0;
  logic [1:0] i_req_op = 2'h0;
  logic [13:0] i_req_addr = 14'h0000;
  logic [17:0] i_req_data = 18'h00000;
  logic [1:0] i_req_byte_en = 2'h0;
  logic i_cancel = 1'b0;
  logic far_sem_wr = 1'b0;
  logic far_mem_wr = 1'b0;
  logic [13:0] far_addr = 14'h0000;
  logic far_bit = 1'b1;
  logic busy = 1'b0;
  logic o_req_ready, o_rsp_valid, o_rsp_granted, o_rsp_busy, o_polling, o_mailbox_pending;
  logic o_array_select_n, o_latch_select_n, o_rw_n, o_oe_n, o_dq_oe, i_busy_n;
  logic o_upper_byte_select_n, o_lower_byte_select_n, i_mailbox_int_n, far_int_n, viol;
  logic [13:0] o_addr;
  logic [17:0] o_rsp_data, o_dq, i_dq, r_data;
  logic [7:0] sem_l, sem_r;
  logic r_gr;
  int num_errors = 0;
  int n_compared = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  dps_host dps_host_inst (.i_clk_sys, .i_rst_n, .i_clk_en, .i_req_valid, .o_req_ready,
    .i_req_op, .i_req_addr, .i_req_data, .i_req_byte_en, .i_cancel, .o_rsp_valid,
    .o_rsp_data, .o_rsp_granted, .o_rsp_busy, .o_polling, .o_mailbox_pending, .o_addr,
    .o_array_select_n, .o_latch_select_n, .o_rw_n, .o_oe_n, .o_upper_byte_select_n,
    .o_lower_byte_select_n, .o_dq, .o_dq_oe, .i_dq, .i_busy_n, .i_mailbox_int_n);
  dps_dev_model dps_dev_model_inst (.i_addr(o_addr), .i_array_select_n(o_array_select_n),
    .i_latch_select_n(o_latch_select_n), .i_rw_n(o_rw_n), .i_oe_n(o_oe_n),
    .i_upper_byte_select_n(o_upper_byte_select_n),
    .i_lower_byte_select_n(o_lower_byte_select_n), .i_dq(o_dq_oe ? o_dq : i_dq),
    .i_far_sem_wr(far_sem_wr), .i_far_mem_wr(far_mem_wr), .i_far_addr(far_addr),
    .i_far_bit(far_bit), .i_force_busy(busy), .o_dq(i_dq), .o_busy_n(i_busy_n),
    .o_int_n(i_mailbox_int_n),
    .o_far_int_n(far_int_n), .o_sem_l(sem_l), .o_sem_r(sem_r), .o_viol(viol));
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk_w(input string nm, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_w
  task automatic chk_b(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_b
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("ERROR wait expected done seen timeout");
      end_sim();
    end
  endtask : tmo
  task automatic do_req(input logic [1:0] op, input logic [13:0] a, input logic [17:0] d,
      input logic [1:0] be);
    int n;
    @(posedge i_clk_sys);
    i_req_valid <= 1'b1;
    i_req_op <= op;
    i_req_addr <= a;
    i_req_data <= d;
    i_req_byte_en <= be;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_req_ready !== 1'b1 && n < 100);
    tmo(n, 100);
    @(posedge i_clk_sys);
    i_req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_rsp_valid !== 1'b1 && n < 3000);
    tmo(n, 3000);
    r_data = o_rsp_data;
    r_gr = o_rsp_granted;
  endtask : do_req
  task automatic far_wr(input logic latch_select_n, input logic [13:0] a, input logic b);
    @(posedge i_clk_sys);
    far_addr <= a;
    far_bit <= b;
    if (latch_select_n) far_sem_wr <= 1'b1;
    else far_mem_wr <= 1'b1;
    @(posedge i_clk_sys);
    far_sem_wr <= 1'b0;
    far_mem_wr <= 1'b0;
  endtask : far_wr
  task automatic wait_sig(input logic mb, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while ((mb ? o_mailbox_pending : o_polling) !== v && n < 200);
    tmo(n, 200);
  endtask : wait_sig
  task automatic t_reset;
    @(negedge i_clk_sys);
    chk_b("ready", 1'b1, o_req_ready);
    chk_w("pins idle", 18'h0003F, {12'h000, o_array_select_n, o_latch_select_n, o_rw_n,
      o_oe_n, o_upper_byte_select_n, o_lower_byte_select_n});
    chk_b("dq drive", 1'b0, o_dq_oe);
    chk_w("latch views", 18'h0FFFF, {2'h0, sem_l, sem_r});
    $display("test reset done");
  endtask : t_reset
  task automatic t_mem;
    logic [17:0] w1, w2;
    w1 = 18'h2A5A5;
    w2 = 18'h15555;
    do_req(2'h1, 14'h0123, w1, 2'h3);
    do_req(2'h1, 14'h0123, w2, 2'h2);
    do_req(2'h0, 14'h0123, 18'h00000, 2'h3);
    chk_w("merged word", {w2[17:9], w1[8:0]}, r_data);
    do_req(2'h0, 14'h0123, 18'h00000, 2'h1);
    chk_w("lower byte", {9'h000, w1[8:0]}, {9'h000, r_data[8:0]});
    chk_b("busy clear", 1'b0, o_rsp_busy);
    // freeze the clock enable in mid strobe; pins and result must survive it
    fork
      do_req(2'h0, 14'h0123, 18'h00000, 2'h3);
      begin
        repeat (7) @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        repeat (20) @(negedge i_clk_sys);
        chk_b("frozen strobe", 1'b0, o_oe_n);
        @(posedge i_clk_sys);
        i_clk_en <= 1'b1;
      end
    join
    chk_w("frozen read", {w2[17:9], w1[8:0]}, r_data);
    $display("test mem done");
  endtask : t_mem
  task automatic t_take;
    do_req(2'h2, 14'h3FF5, 18'h00000, 2'h0);
    chk_b("take granted", 1'b1, r_gr);
    chk_w("take data", 18'h00000, r_data);
    chk_w("latch views", 18'h0DFFF, {2'h0, sem_l, sem_r});
    do_req(2'h3, 14'h0005, 18'h00000, 2'h0);
    chk_b("give granted", 1'b0, r_gr);
    chk_w("latch views", 18'h0FFFF, {2'h0, sem_l, sem_r});
    $display("test take done");
  endtask : t_take
  task automatic t_wait(input logic [2:0] i, input logic cn);
    far_wr(1'b1, {11'h000, i}, 1'b0);
    fork
      do_req(2'h2, {11'h000, i}, 18'h00000, 2'h0);
      begin
        wait_sig(1'b0, 1'b1);
        repeat (60) @(posedge i_clk_sys);
        if (cn) i_cancel <= 1'b1;
        else far_wr(1'b1, {11'h000, i}, 1'b1);
        @(posedge i_clk_sys);
        i_cancel <= 1'b0;
      end
    join
    if (cn) far_wr(1'b1, {11'h000, i}, 1'b1);
    chk_b("granted", ~cn, r_gr);
    chk_b("near view", cn, sem_l[i]);
    chk_b("far view", 1'b1, sem_r[i]);
    if (!cn) do_req(2'h3, {11'h000, i}, 18'h00000, 2'h0);
    $display("test wait done");
  endtask : t_wait
  task automatic t_mbox;
    far_wr(1'b0, dps_pkg::MAILBOX_LEFT_ADDR, 1'b0);
    wait_sig(1'b1, 1'b1);
    @(posedge i_clk_sys);
    busy <= 1'b1;
    fork
      do_req(2'h1, dps_pkg::MAILBOX_RIGHT_ADDR, 18'h0ABCD, 2'h3);
      begin
        repeat (40) @(posedge i_clk_sys);
        chk_b("far int busy", 1'b1, far_int_n);
        busy <= 1'b0;
      end
    join
    chk_b("far int", 1'b0, far_int_n);
    @(posedge i_clk_sys);
    busy <= 1'b1;
    do_req(2'h0, dps_pkg::MAILBOX_LEFT_ADDR, 18'h00000, 2'h3);
    chk_b("busy seen", 1'b1, o_rsp_busy);
    repeat (10) @(posedge i_clk_sys);
    chk_b("pending under busy", 1'b1, o_mailbox_pending);
    busy <= 1'b0;
    do_req(2'h0, dps_pkg::MAILBOX_RIGHT_ADDR, 18'h00000, 2'h3);
    chk_w("far mailbox", 18'h0ABCD, r_data);
    chk_b("pending kept", 1'b1, o_mailbox_pending);
    do_req(2'h0, dps_pkg::MAILBOX_LEFT_ADDR, 18'h00000, 2'h3);
    wait_sig(1'b1, 1'b0);
    chk_b("pending", 1'b0, o_mailbox_pending);
    $display("test mbox done");
  endtask : t_mbox
  initial begin
    repeat (3) @(posedge i_clk_sys);
    t_reset();
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_mem();
    t_take();
    t_wait(3'h2, 1'b0);
    t_wait(3'h3, 1'b1);
    t_mbox();
    chk_b("protocol", 1'b0, viol);
    end_sim();
  end
endmodule : dps_host_bench
